// file: aah_handler.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Return code 00h means received, FFh means invalid field.
// - Tag stays allocated after ack; only a new configuration changes it.
// - Alert code is type, subtype, type-information bytes in that order.
// - Ack whose alert code differs from outstanding alert is discarded.
// - Tag or code mismatch against queue head leaves queue unchanged.
// - Full match removes head entry then sends next pending alert.
// - Types 00h/01h subtype 01h put port in privileged mode.
// - Type 03h invalid-message alerts leave mode unchanged.
// - Type 04h protocol-error alerts leave mode unchanged.
// - Type 06h warnings leave mode unchanged except hardware fault.
// - Type 06h subtype 03h puts port in wrap mode.
// - Types 10h to 19h put port in privileged mode.
// - Codes BCh to C0h come only from master, never sent by node.
// - Resend alert every 500 ms until ack or reset.
// - One alert outstanding per port; later alerts queue behind it.
// - Ack with no alert pending is discarded.
module aah_handler #(
    parameter int DEPTH     = aah_pkg::QUEUE_DEPTH,
    parameter int RETRY_CYC = aah_pkg::RETRY_CYC
) (
    // Clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        clk_en_i,
    // New alert from node logic
    input  wire logic        alert_vld_i,
    input  wire logic [23:0] alert_code_i,
    // Tag from port configuration
    input  wire logic        cfg_tag_vld_i,
    input  wire logic [15:0] cfg_tag_i,
    // Received message byte stream
    input  wire logic        rx_vld_i,
    input  wire logic        rx_sof_i,
    input  wire logic [7:0]  rx_byte_i,
    // Alert transmit request
    output logic             tx_req_o,
    output logic [15:0]      tx_tag_o,
    output logic [23:0]      tx_code_o,
    input  wire logic        tx_done_i,
    // Status
    output logic             alert_ready_o,
    output logic             pending_o,
    output logic [1:0]       port_mode_o,
    output logic             ack_ok_o,
    output logic             ack_drop_o
);
    import aah_pkg::*;

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    ////////////////////////////////////////////////////////////////////
    aah_state_e      state;
    aah_state_e      next_state;
    logic [23:0]     queue [DEPTH];
    logic [23:0]     next_queue [DEPTH];
    logic [AW:0]     count;
    logic [AW:0]     next_count;
    logic [15:0]     tag;
    logic [15:0]     next_tag;
    logic [31:0]     timer;
    logic [31:0]     next_timer;
    logic [2:0]      rx_idx;
    logic [2:0]      next_rx_idx;
    logic [7:0]      rx_buf [ACK_LEN];
    logic [7:0]      next_rx_buf [ACK_LEN];
    logic            rx_done;
    logic            next_rx_done;
    logic [1:0]      next_mode;
    logic            next_tx_req;
    logic            next_ok;
    logic            next_drop;
    logic [1:0]      map_mode;
    logic            push;
    logic            pop;
    logic            match;
    logic [15:0]     ack_tag;
    logic [23:0]     ack_code;

    // Mode implied by an incoming alert
    aah_mode_map u_map (
        .type_i (alert_code_i[23:16]),
        .sub_i  (alert_code_i[15:8]),
        .mode_o (map_mode)
    );

    ////////////////////////////////////////////////////////////////////
    // Collect an acknowledgement; only code 07h frames are kept
    always_comb begin
        next_rx_idx  = rx_idx;
        next_rx_done = 1'b0;
        for (int i = 0; i < ACK_LEN; i++) begin
            next_rx_buf[i] = rx_buf[i];
        end
        if (rx_vld_i) begin
            if (rx_sof_i) begin
                next_rx_buf[0] = rx_byte_i;
                next_rx_idx    = 3'd1;
            end else if (rx_idx != 3'd0 && rx_idx < 3'(ACK_LEN)) begin
                next_rx_buf[rx_idx] = rx_byte_i;
                next_rx_idx         = rx_idx + 3'd1;
                if (rx_idx == 3'(BYTE_INFO) && rx_buf[BYTE_CODE] == ACK_MSG_CODE) begin
                    next_rx_done = 1'b1;
                end
            end
        end
    end

    assign ack_tag  = {rx_buf[BYTE_TAG_HI], rx_buf[BYTE_TAG_LO]};
    assign ack_code = {rx_buf[BYTE_TYPE], rx_buf[BYTE_SUB], rx_buf[BYTE_INFO]};
    // head compare, either return code accepted
    assign match    = (count != '0) && (ack_tag == tag) && (ack_code == queue[0]);

    ////////////////////////////////////////////////////////////////////
    // Queue, tag, retry timer and sender state
    always_comb begin
        next_state  = state;
        next_count  = count;
        next_tag    = tag;
        next_timer  = timer;
        next_mode   = port_mode_o;
        next_tx_req = 1'b0;
        next_ok     = 1'b0;
        next_drop   = 1'b0;
        for (int i = 0; i < DEPTH; i++) begin
            next_queue[i] = queue[i];
        end
        if (cfg_tag_vld_i) begin
            next_tag = cfg_tag_i;
        end
        pop  = rx_done && match && state == AAH_WAIT;
        push = alert_vld_i && alert_ready_o
               && !(alert_code_i[23:16] >= TY_MASTER_FIRST && alert_code_i[23:16] <= TY_MASTER_LAST);
        if (rx_done) begin
            next_ok   = pop;
            next_drop = !pop;
        end
        if (pop) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                next_queue[i] = queue[i + 1];
            end
            next_count = count - 1'b1;
        end
        if (push) begin
            next_queue[AW'(next_count)] = alert_code_i;
            next_count = next_count + 1'b1;
            if (map_mode != MODE_KEEP) begin
                next_mode = map_mode;
            end
        end
        case (state)
            AAH_IDLE: begin
                if (count != '0) begin
                    next_state  = AAH_SEND;
                    next_tx_req = 1'b1;
                end
            end
            AAH_SEND: begin
                next_tx_req = !tx_done_i;
                if (tx_done_i) begin
                    next_state = AAH_WAIT;
                    next_timer = '0;
                end
            end
            AAH_WAIT: begin
                next_timer = timer + 32'd1;
                if (pop) begin
                    next_state = AAH_IDLE;
                end else if (timer >= 32'(RETRY_CYC - 1)) begin
                    next_state  = AAH_SEND;
                    next_tx_req = 1'b1;
                end
            end
            default: next_state = AAH_IDLE;
        endcase
    end

    // Registers, frozen while clock enable is low
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state         <= AAH_IDLE;
            count         <= '0;
            tag           <= '0;
            timer         <= '0;
            rx_idx        <= '0;
            rx_done       <= 1'b0;
            tx_req_o      <= 1'b0;
            tx_tag_o      <= '0;
            tx_code_o     <= '0;
            alert_ready_o <= 1'b0;
            pending_o     <= 1'b0;
            port_mode_o   <= MODE_NORMAL;
            ack_ok_o      <= 1'b0;
            ack_drop_o    <= 1'b0;
            for (int i = 0; i < DEPTH; i++) begin
                queue[i] <= '0;
            end
            for (int i = 0; i < ACK_LEN; i++) begin
                rx_buf[i] <= '0;
            end
        end else if (clk_en_i) begin
            state         <= next_state;
            count         <= next_count;
            tag           <= next_tag;
            timer         <= next_timer;
            rx_idx        <= next_rx_idx;
            rx_done       <= next_rx_done;
            tx_req_o      <= next_tx_req;
            tx_tag_o      <= next_tag;
            tx_code_o     <= next_queue[0];
            alert_ready_o <= next_count < (AW + 1)'(DEPTH) - (AW + 1)'(1);
            pending_o     <= next_count != '0;
            port_mode_o   <= next_mode;
            ack_ok_o      <= next_ok;
            ack_drop_o    <= next_drop;
            queue         <= next_queue;
            rx_buf        <= next_rx_buf;
        end
    end

    ////////////////////////////////////////////////////////////////////
    sequence s_good_ack;
        rx_done && match && state == AAH_WAIT;
    endsequence

    AST_POP_SHRINKS: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        s_good_ack and (clk_en_i && !push) |=> count == $past(count) - 1'b1)
        else $error("matching ack did not pop queue");
    AST_NOMATCH_KEEPS: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        rx_done && !match && clk_en_i && !push |=> count == $past(count))
        else $error("mismatched ack changed queue");
    AST_DROP_EMPTY: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        rx_done && count == '0 && clk_en_i |=> ack_drop_o && !ack_ok_o)
        else $error("ack with nothing pending not dropped");
    AST_CODE_MISMATCH: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        rx_done && ack_code != queue[0] && clk_en_i |=> !ack_ok_o)
        else $error("ack with wrong alert code accepted");
    AST_TAG_KEPT: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        pop && !cfg_tag_vld_i && clk_en_i |=> tag == $past(tag))
        else $error("tag changed on ack");
    AST_ONE_OUT: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        state == AAH_WAIT && !pop |=> state != AAH_IDLE)
        else $error("second alert released before ack");
    AST_RETRY: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        state == AAH_WAIT && timer >= 32'(RETRY_CYC - 1) && !pop && clk_en_i |=> tx_req_o)
        else $error("alert not resent after timeout");
    AST_WRAP: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        push && alert_code_i[23:8] == {TY_WARN, SUB_HW_FAULT} && clk_en_i |=> port_mode_o == MODE_WRAP)
        else $error("hardware fault alert did not set wrap");
    AST_PRIV: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        push && alert_code_i[23:16] >= TY_ERP_FIRST && alert_code_i[23:16] <= TY_ERP_LAST && clk_en_i
        |=> port_mode_o == MODE_PRIV)
        else $error("link exit alert did not set privileged");
endmodule // aah_handler

// file: aah_master_model.sv
`timescale 1ns/10ps
// Web master stand-in: completes alert sends and returns acknowledgements
module aah_master_model (
    // Clock
    input  wire logic        core_clk_i,
    // Alert send request from the node
    input  wire logic        tx_req_i,
    input  wire logic [15:0] tx_tag_i,
    input  wire logic [23:0] tx_code_i,
    input  wire logic [3:0]  slow_i,
    output logic             tx_done_o,
    // Acknowledgement byte stream
    output logic             rx_vld_o,
    output logic             rx_sof_o,
    output logic [7:0]       rx_byte_o
);
    import aah_pkg::*;
    int          sends = 0;
    logic [15:0] last_tag;
    logic [23:0] last_code;
    logic [3:0]  cnt = 4'h0;
    logic        held = 1'b0;

    initial begin
        tx_done_o = 1'b0;
        rx_vld_o  = 1'b0;
        rx_sof_o  = 1'b0;
        rx_byte_o = 8'h00;
    end

    ////////////////////////////////////////////////////////////////
    // Send completion, delayed by slow_i so a stalled link can be mimicked
    always @(posedge core_clk_i) begin
        tx_done_o <= 1'b0;
        if (tx_req_i && !held) begin
            if (cnt == slow_i) begin
                tx_done_o <= 1'b1;
                sends     <= sends + 1;
                last_tag  <= tx_tag_i;
                last_code <= tx_code_i;
                cnt       <= 4'h0;
                held      <= 1'b1;
            end else begin
                cnt <= cnt + 4'h1;
            end
        end
        if (!tx_req_i) begin
            held <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Acknowledgement frame with a gap; idle byte is inverted, never stale
    // frame layout
    task automatic send_ack(input logic [7:0] ret, input logic [15:0] tag, input logic [23:0] code);
        logic [7:0] msg [7];
        msg = '{ACK_MSG_CODE, ret, tag[15:8], tag[7:0], code[23:16], code[15:8], code[7:0]};
        for (int i = 0; i < ACK_LEN; i++) begin
            @(posedge core_clk_i);
            rx_vld_o  <= 1'b1;
            rx_sof_o  <= (i == 0);
            rx_byte_o <= msg[i];
            if (i == 3) begin
                @(posedge core_clk_i);
                rx_vld_o  <= 1'b0;
                rx_byte_o <= ~msg[i];
            end
        end
        @(posedge core_clk_i);
        rx_vld_o  <= 1'b0;
        rx_sof_o  <= 1'b0;
        rx_byte_o <= ~msg[6];
    endtask
endmodule // aah_master_model

// file: aah_mode_map.sv
`timescale 1ns/10ps
// Maps an alert code to the port mode it implies
module aah_mode_map (
    // Alert code
    input  wire logic [7:0] type_i,
    input  wire logic [7:0] sub_i,
    // Mode result
    output logic [1:0]      mode_o
);
    import aah_pkg::*;

    // Type decode; master-only codes also arrive here and fall through to keep
    always_comb begin
        mode_o = MODE_KEEP;
        if (type_i == TY_PORT_OPER || type_i == TY_ADDR_ERR) begin
            mode_o = MODE_PRIV;
        end
        else if (type_i >= TY_ERP_FIRST && type_i <= TY_ERP_LAST) begin
            mode_o = MODE_PRIV;
        end
        else if (type_i == TY_WARN && sub_i == SUB_HW_FAULT) begin
            mode_o = MODE_WRAP;
        end
        else if (type_i == TY_INVALID || type_i == TY_PROTO || type_i == TY_WARN) begin
            mode_o = MODE_KEEP;
        end
    end
endmodule // aah_mode_map

// file: aah_pkg.sv
package aah_pkg;
    // Acknowledgement message layout
    localparam logic [7:0] ACK_MSG_CODE     = 8'h07;
    localparam int         ACK_LEN          = 7;
    localparam int         BYTE_CODE        = 0;
    localparam int         BYTE_RET         = 1;
    localparam int         BYTE_TAG_HI      = 2;
    localparam int         BYTE_TAG_LO      = 3;
    localparam int         BYTE_TYPE        = 4;
    localparam int         BYTE_SUB         = 5;
    localparam int         BYTE_INFO        = 6;
    // Return codes
    localparam logic [7:0] RET_OK           = 8'h00;
    localparam logic [7:0] RET_BAD_FIELD    = 8'hFF;
    // Alert types and subtypes
    localparam logic [7:0] TY_PORT_OPER     = 8'h00;
    localparam logic [7:0] TY_ADDR_ERR      = 8'h01;
    localparam logic [7:0] TY_INVALID       = 8'h03;
    localparam logic [7:0] TY_PROTO         = 8'h04;
    localparam logic [7:0] TY_WARN          = 8'h06;
    localparam logic [7:0] TY_ERP_FIRST     = 8'h10;
    localparam logic [7:0] TY_ERP_LAST      = 8'h19;
    localparam logic [7:0] TY_MASTER_FIRST  = 8'hBC;
    localparam logic [7:0] TY_MASTER_LAST   = 8'hC0;
    localparam logic [7:0] SUB_HW_FAULT     = 8'h03;
    // Port modes
    localparam logic [1:0] MODE_KEEP        = 2'h0;
    localparam logic [1:0] MODE_WRAP        = 2'h1;
    localparam logic [1:0] MODE_NORMAL      = 2'h2;
    localparam logic [1:0] MODE_PRIV        = 2'h3;
    // Retransmit timing
    localparam int         CLK_MHZ          = 200;
    localparam int         RETRY_MS         = 500;
    localparam int         RETRY_CYC        = RETRY_MS * 1000 * CLK_MHZ;
    localparam int         QUEUE_DEPTH      = 4;
    typedef enum logic [1:0] {AAH_IDLE, AAH_SEND, AAH_WAIT} aah_state_e;
endpackage

// file: async_alert_code_reply_handler_tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module async_alert_code_reply_handler_tb_top;
    import aah_pkg::*;
    logic        clk = 0, rst_b = 0, alert_vld = 0, cfg_tag_vld = 0, tx_done, clk_en = 1;
    logic        rx_vld, rx_sof, tx_req, alert_ready, pending, ack_ok, ack_drop;
    logic [7:0]  rx_byte;
    logic [15:0] cfg_tag = 16'h0000, tx_tag, tag = 16'hA55A;
    logic [23:0] alert_code = 24'h000000, tx_code;
    logic [1:0]  port_mode;
    logic [3:0]  slow = 4'h0;
    logic [25:0] tbl [20] = '{26'h2030100, 26'h1060300, 26'h1040300, 26'h3000100, 26'h3060500,
        26'h1060300, 26'h3100000, 26'h1060300, 26'h3134500, 26'h1060300, 26'h319A5C3, 26'h306027E,
        26'h3060100, 26'h3060400, 26'h3060600, 26'h3030200, 26'h3040100, 26'h3040400, 26'h1060300,
        26'h3010100};
    logic [39:0] bad [5] = '{40'h0001000000, 40'h0100000000, 40'h0000000001, 40'h0000000100,
        40'h0000010000};
    int          mismatches = 0, checked = 0, cycles = 0, n;

    // Clock, and a cycle ceiling so a hang still ends in a verdict
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            wrap_up();
        end
    end

    aah_handler #(.DEPTH(4), .RETRY_CYC(50)) DUT (.core_clk_i(clk), .rst_b_i(rst_b), .clk_en_i(clk_en),
        .alert_vld_i(alert_vld), .alert_code_i(alert_code), .cfg_tag_vld_i(cfg_tag_vld),
        .cfg_tag_i(cfg_tag), .rx_vld_i(rx_vld), .rx_sof_i(rx_sof), .rx_byte_i(rx_byte),
        .tx_req_o(tx_req), .tx_tag_o(tx_tag), .tx_code_o(tx_code), .tx_done_i(tx_done),
        .alert_ready_o(alert_ready), .pending_o(pending), .port_mode_o(port_mode),
        .ack_ok_o(ack_ok), .ack_drop_o(ack_drop));
    aah_master_model master (.core_clk_i(clk), .tx_req_i(tx_req), .tx_tag_i(tx_tag),
        .tx_code_i(tx_code), .slow_i(slow), .tx_done_o(tx_done), .rx_vld_o(rx_vld),
        .rx_sof_o(rx_sof), .rx_byte_o(rx_byte));

    ////////////////////////////////////////////////////////////////
    // Shared steps: checks at falling edges, drives just after rising ones
    task automatic push(input logic [23:0] code);
        @(negedge clk);
        `CHK("alert_ready", 1'b1, alert_ready)
        @(posedge clk);
        alert_vld  <= 1'b1;
        alert_code <= code;
        @(posedge clk);
        alert_vld  <= 1'b0;
    endtask
    task automatic wait_send();
        n = master.sends;
        for (int i = 0; i < 90; i++) begin
            @(negedge clk);
            if (master.sends != n) break;
        end
        `CHK("alert_sent", 1'b1, master.sends != n)
    endtask
    task automatic wait_ack(input logic ok);
        for (int i = 0; i < 20; i++) begin
            @(negedge clk);
            if (ack_ok || ack_drop) break;
        end
        `CHK("ack_ok", ok, ack_ok)
        `CHK("ack_drop", !ok, ack_drop)
    endtask
    task automatic send_one(input logic [23:0] code, input logic [1:0] mode);
        push(code);
        wait_send();
        `CHK("alert_code", code, master.last_code)
        `CHK("alert_tag", tag, master.last_tag)
        master.send_ack(RET_OK, tag, code);
        wait_ack(1'b1);
        `CHK("port_mode", mode, port_mode)
        `CHK("pending", 1'b0, pending)
    endtask

    ////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic s_modes();
        foreach (tbl[i]) send_one(tbl[i][23:0], tbl[i][25:24]);
    endtask
    task automatic s_mismatch();
        push(24'h040300);
        wait_send();
        foreach (bad[i]) begin
            master.send_ack(RET_OK, tag ^ bad[i][39:24], 24'h040300 ^ bad[i][23:0]);
            wait_ack(1'b0);
            `CHK("pending_kept", 1'b1, pending)
        end
        // Return code of invalid field still counts as acknowledgement
        master.send_ack(RET_BAD_FIELD, tag, 24'h040300);
        wait_ack(1'b1);
        master.send_ack(RET_OK, tag, 24'h040300);
        wait_ack(1'b0);
    endtask
    task automatic s_master_codes();
        for (int t = 8'hBC; t <= 8'hC0; t++) begin
            push({t[7:0], 16'h0000});
            repeat (4) @(negedge clk);
            `CHK("master_code_pending", 1'b0, pending)
        end
    endtask
    task automatic s_queue();
        slow = 4'h8;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            alert_vld  <= (i < 3);
            alert_code <= 24'h040100 + 24'(i) * 24'h000100;
        end
        @(negedge clk);
        `CHK("alert_ready_full", 1'b0, alert_ready)
        for (int i = 0; i < 3; i++) begin
            wait_send();
            repeat (12) @(negedge clk);
            `CHK("head_code", 24'h040100 + 24'(i) * 24'h000100, master.last_code)
            master.send_ack(RET_OK, tag, master.last_code);
            wait_ack(1'b1);
        end
        `CHK("queue_empty", 1'b0, pending)
        slow = 4'h0;
    endtask
    task automatic s_retry();
        push(24'h060100);
        wait_send();
        wait_send();
        `CHK("resent_code", 24'h060100, master.last_code)
        master.send_ack(RET_OK, tag, 24'h060100);
        wait_ack(1'b1);
    endtask
    task automatic s_new_tag();
        @(posedge clk);
        cfg_tag_vld <= 1'b1;
        cfg_tag     <= 16'h3C96;
        @(posedge clk);
        cfg_tag_vld <= 1'b0;
        tag = 16'h3C96;
        send_one(24'h040400, 2'h3);
    endtask
    // Clock enable low must freeze the retry timer too
    task automatic s_freeze();
        push(24'h060400);
        wait_send();
        n = master.sends;
        @(posedge clk);
        clk_en <= 1'b0;
        repeat (60) @(posedge clk);
        clk_en <= 1'b1;
        @(negedge clk);
        `CHK("frozen_no_resend", n, master.sends)
        `CHK("frozen_pending", 1'b1, pending)
        master.send_ack(RET_OK, tag, 24'h060400);
        wait_ack(1'b1);
    endtask

    ////////////////////////////////////////////////////////////////
    // Verdict and main sequence
    task automatic wrap_up();
        if (mismatches == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_b       <= 1'b1;
        @(posedge clk);
        cfg_tag_vld <= 1'b1;
        cfg_tag     <= tag;
        @(posedge clk);
        cfg_tag_vld <= 1'b0;
        s_modes();
        s_mismatch();
        s_master_codes();
        s_queue();
        s_retry();
        s_new_tag();
        s_freeze();
        wrap_up();
    end
endmodule // async_alert_code_reply_handler_tb_top
